// file: common/osi_pkg.sv
// Package of constants and types for the output status indication block
package osi_pkg;
  // Register byte offsets
  localparam logic [7:0] OSI_OFF_CTRL = 8'h00;
  localparam logic [7:0] OSI_OFF_FREQ = 8'h04;
  localparam logic [7:0] OSI_OFF_TERM = 8'h08;
  localparam logic [7:0] OSI_OFF_CH0 = 8'h0c;
  localparam logic [7:0] OSI_OFF_CH1 = 8'h10;
  localparam logic [7:0] OSI_OFF_CH2 = 8'h14;
  localparam logic [7:0] OSI_OFF_EVENT = 8'h18;
  localparam logic [7:0] OSI_OFF_STAT = 8'h1c;
  localparam logic [7:0] OSI_OFF_MASK = 8'h20;
  // Control register bit positions
  localparam int OSI_CTRL_FAULT = 0;
  localparam int OSI_CTRL_TMO = 1;
  localparam int OSI_CTRL_BOOT = 2;
  localparam int OSI_CTRL_UPLD = 3;
  // Event strobe bit positions
  localparam int OSI_EV_ADDR = 0;
  localparam int OSI_EV_BAUD = 1;
  localparam int OSI_EV_PAR = 2;
  localparam int OSI_EV_RTMO = 3;
  // Status bit positions
  localparam int OSI_ST_CH0 = 0;
  localparam int OSI_ST_CFG = 3;
  localparam int OSI_ST_FAULT = 4;
  localparam int OSI_ST_TMO = 5;
  localparam int OSI_ST_W = 6;
  // Frequency reset value and legal range
  localparam logic [3:0] OSI_FREQ_RST = 4'h1;
  localparam logic [3:0] OSI_FREQ_MIN = 4'h1;
  localparam logic [3:0] OSI_FREQ_MAX = 4'h8;
  // Timing constants
  localparam int OSI_CLK_MHZ = 100;
  localparam int OSI_BLINK_MS = 100;
  localparam int OSI_BLINK_CYC = OSI_BLINK_MS * 1000 * OSI_CLK_MHZ;
  localparam int OSI_CHG_MS = 1000;
  localparam int OSI_CHG_CYC = OSI_CHG_MS * 1000 * OSI_CLK_MHZ;
  localparam int OSI_ACT_MS = 20;
  localparam int OSI_ACT_CYC = OSI_ACT_MS * 1000 * OSI_CLK_MHZ;
  // RGB lamp carrier
  typedef struct packed {
    logic red;
    logic green;
    logic blue;
  } osi_rgb_t;
  // Power-on sequence states
  typedef enum logic [2:0] {OSI_S_GREEN, OSI_S_RED, OSI_S_BLUE, OSI_S_RUN} osi_state_t;
endpackage : osi_pkg

// file: logic/osi_pulse_stretch.sv
// Retriggerable pulse stretcher used for change and link activity blinks
module osi_pulse_stretch #(
  parameter int LEN = 1000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic trig,
  output logic active
);
  localparam int W = $clog2(LEN + 1);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  // Reload on trigger, else count down
  always_comb begin
    cnt_next = cnt_reg;
    if (trig) begin
      cnt_next = W'(LEN);
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  // Counter register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign active = (cnt_reg != '0);
endmodule : osi_pulse_stretch

// file: logic/osi_top.sv
// Status lamp logic of a three-channel converter with AXI4-Lite registers
module osi_top #(
  parameter int BLINK_CYC = osi_pkg::OSI_BLINK_CYC,
  parameter int CHG_CYC = osi_pkg::OSI_CHG_CYC,
  parameter int ACT_CYC = osi_pkg::OSI_ACT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_active_pin,
  input wire logic rx_active_pin,
  output osi_pkg::osi_rgb_t first_channel_lamp,
  output osi_pkg::osi_rgb_t second_channel_lamp,
  output osi_pkg::osi_rgb_t third_channel_lamp,
  output logic tx_lamp,
  output logic rx_lamp,
  output logic bus_terminator,
  output logic [3:0] pwm_freq_khz,
  output logic irq
);
  import osi_pkg::*;

  localparam int BW = $clog2(BLINK_CYC + 1);

  logic [3:0] ctrl_reg, ctrl_next;
  logic [3:0] freq_reg, freq_next;
  logic term_reg, term_next;
  logic [15:0] ch_reg [3];
  logic [15:0] ch_next [3];
  logic [2:0] cmd_reg, cmd_next;
  localparam int ST_W_L = OSI_ST_W;
  logic [ST_W_L-1:0] stat_reg, stat_next;
  logic [ST_W_L-1:0] mask_reg, mask_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic aw_got_reg, aw_got_next, w_got_reg, w_got_next, bvalid_reg, bvalid_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic wr_fire, aw_have, w_have;
  logic [2:0] ch_wr;
  logic [3:0] ev_wr;
  osi_state_t st_reg, st_next;
  logic [BW-1:0] bc_reg, bc_next;
  logic ph_reg, ph_next;
  logic [1:0] tx_s_reg, rx_s_reg;
  logic [3:0] ev_act;
  logic [2:0] ch_act;
  logic tx_act, rx_act;
  osi_rgb_t lamp [3];
  osi_rgb_t lamp_reg [3];

  // Address decode helper
  function automatic logic osi_mapped(input logic [7:0] a);
    osi_mapped = (a[1:0] == 2'b00) && (a <= OSI_OFF_MASK);
  endfunction : osi_mapped

  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_got_reg && !bvalid_reg;
  assign s_axi_wready = !w_got_reg && !bvalid_reg;
  assign aw_have = aw_got_reg || (s_axi_awvalid && s_axi_awready);
  assign w_have = w_got_reg || (s_axi_wvalid && s_axi_wready);
  assign wr_fire = aw_have && w_have && !bvalid_reg;
  always_comb begin
    aw_got_next = aw_got_reg;
    w_got_next = w_got_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_got_next = 1'b0;
      w_got_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = osi_mapped(awaddr_next) ? 2'b00 : 2'b10;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
  end

  // Register writes and status flags
  always_comb begin
    ctrl_next = ctrl_reg;
    freq_next = freq_reg;
    term_next = term_reg;
    ch_next = ch_reg;
    cmd_next = cmd_reg;
    mask_next = mask_reg;
    stat_next = stat_reg;
    ch_wr = 3'b000;
    ev_wr = 4'h0;
    if (wr_fire && wstrb_next[0]) begin
      case (awaddr_next)
        OSI_OFF_CTRL: ctrl_next = wdata_next[3:0];
        OSI_OFF_FREQ: begin
          if (wdata_next[3:0] >= OSI_FREQ_MIN && wdata_next[3:0] <= OSI_FREQ_MAX && wdata_next[31:4] == '0) begin
            freq_next = wdata_next[3:0];
          end
        end
        OSI_OFF_TERM: term_next = wdata_next[0];
        OSI_OFF_EVENT: ev_wr = wdata_next[3:0];
        OSI_OFF_MASK: mask_next = wdata_next[ST_W_L-1:0];
        default: ;
      endcase
    end
    if (wr_fire && (wstrb_next[1:0] == 2'b11)) begin
      for (int i = 0; i < 3; i++) begin
        if (awaddr_next == OSI_OFF_CH0 + 8'(4 * i)) begin
          ch_wr[i] = 1'b1;
          ch_next[i] = wdata_next[15:0];
          cmd_next[i] = 1'b1;
        end
      end
    end
    // Write one to clear, new events win
    if (wr_fire && awaddr_next == OSI_OFF_STAT && wstrb_next[0]) begin
      stat_next = stat_reg & ~wdata_next[ST_W_L-1:0];
    end
    stat_next[2:0] = stat_next[2:0] | ch_wr;
    stat_next[OSI_ST_CFG] = stat_next[OSI_ST_CFG] | (|ev_wr);
    stat_next[OSI_ST_FAULT] = stat_next[OSI_ST_FAULT] | (ctrl_next[OSI_CTRL_FAULT] & ~ctrl_reg[OSI_CTRL_FAULT]);
    stat_next[OSI_ST_TMO] = stat_next[OSI_ST_TMO] | (ctrl_next[OSI_CTRL_TMO] & ~ctrl_reg[OSI_CTRL_TMO]);
  end

  // Read channel
  assign s_axi_arready = !rvalid_reg;
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = osi_mapped(s_axi_araddr) ? 2'b00 : 2'b10;
      case (s_axi_araddr)
        OSI_OFF_CTRL: rdata_next = {28'h0, ctrl_reg};
        OSI_OFF_FREQ: rdata_next = {28'h0, freq_reg};
        OSI_OFF_TERM: rdata_next = {31'h0, term_reg};
        OSI_OFF_CH0: rdata_next = {16'h0, ch_reg[0]};
        OSI_OFF_CH1: rdata_next = {16'h0, ch_reg[1]};
        OSI_OFF_CH2: rdata_next = {16'h0, ch_reg[2]};
        OSI_OFF_EVENT: rdata_next = {25'h0, (st_reg == OSI_S_RUN), tx_act, rx_act, ev_act};
        OSI_OFF_STAT: rdata_next = {26'h0, stat_reg};
        OSI_OFF_MASK: rdata_next = {26'h0, mask_reg};
        default: rdata_next = 32'h0;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign irq = |(stat_reg & mask_reg);
  assign bus_terminator = term_reg;
  assign pwm_freq_khz = freq_reg;

  // Blink timebase and power-on sequence
  always_comb begin
    bc_next = bc_reg;
    ph_next = ph_reg;
    st_next = st_reg;
    if (bc_reg == BW'(BLINK_CYC - 1)) begin
      bc_next = '0;
      ph_next = !ph_reg;
      if (ph_reg) begin
        case (st_reg)
          OSI_S_GREEN: st_next = OSI_S_RED;
          OSI_S_RED: st_next = OSI_S_BLUE;
          OSI_S_BLUE: st_next = OSI_S_RUN;
          OSI_S_RUN: st_next = OSI_S_RUN;
          default: st_next = OSI_S_GREEN;
        endcase
      end
    end else begin
      bc_next = bc_reg + 1'b1;
    end
  end

  // Retriggerable change and activity blinks
  for (genvar g = 0; g < 4; g++) begin : g_ev
    osi_pulse_stretch #(.LEN(CHG_CYC)) u_ev (
      .aclk(aclk), .aresetn(aresetn), .trig(ev_wr[g]), .active(ev_act[g]));
  end
  for (genvar g = 0; g < 3; g++) begin : g_ch
    osi_pulse_stretch #(.LEN(CHG_CYC)) u_ch (
      .aclk(aclk), .aresetn(aresetn), .trig(ch_wr[g]), .active(ch_act[g]));
  end
  osi_pulse_stretch #(.LEN(ACT_CYC)) u_tx (
    .aclk(aclk), .aresetn(aresetn), .trig(tx_s_reg[1]), .active(tx_act));
  osi_pulse_stretch #(.LEN(ACT_CYC)) u_rx (
    .aclk(aclk), .aresetn(aresetn), .trig(rx_s_reg[1]), .active(rx_act));

  // Lamp priority selection
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      lamp[i] = '0;
      if (st_reg != OSI_S_RUN) begin
        lamp[i].green = ph_reg && st_reg == OSI_S_GREEN;
        lamp[i].red = ph_reg && st_reg == OSI_S_RED;
        lamp[i].blue = ph_reg && st_reg == OSI_S_BLUE;
      end else if (ctrl_reg[OSI_CTRL_UPLD]) begin
        lamp[i].blue = ph_reg;
      end else if (ctrl_reg[OSI_CTRL_BOOT]) begin
        lamp[i].blue = ph_reg && i < 2;
      end else if (|ev_act) begin
        lamp[i].blue = ph_reg && ((i == 0 && ev_act[OSI_EV_ADDR]) || (i == 1 && ev_act[OSI_EV_BAUD]) ||
          (i == 2 && ev_act[OSI_EV_PAR]) || (i > 0 && ev_act[OSI_EV_RTMO]));
      end else if (ctrl_reg[OSI_CTRL_TMO]) begin
        lamp[i].red = ph_reg;
        lamp[i].green = ph_reg;
      end else if (ctrl_reg[OSI_CTRL_FAULT]) begin
        lamp[i].red = 1'b1;
      end else if (!cmd_reg[i] || ch_reg[i] == 16'h0) begin
        lamp[i].red = !ch_act[i] || ph_reg;
        lamp[i].green = !ch_act[i] || ph_reg;
      end else begin
        lamp[i].green = !ch_act[i] || ph_reg;
      end
    end
  end

  assign tx_lamp = !(tx_act && ph_reg);
  assign rx_lamp = rx_act && ph_reg;
  assign first_channel_lamp = lamp_reg[0];
  assign second_channel_lamp = lamp_reg[1];
  assign third_channel_lamp = lamp_reg[2];

  // All state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= '0;
      freq_reg <= OSI_FREQ_RST;
      term_reg <= 1'b0;
      ch_reg <= '{default: 16'h0};
      cmd_reg <= '0;
      stat_reg <= '0;
      mask_reg <= '0;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'b00;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= 2'b00;
      st_reg <= OSI_S_GREEN;
      bc_reg <= '0;
      ph_reg <= 1'b0;
      tx_s_reg <= 2'b00;
      rx_s_reg <= 2'b00;
      lamp_reg <= '{default: '0};
    end else begin
      ctrl_reg <= ctrl_next;
      freq_reg <= freq_next;
      term_reg <= term_next;
      ch_reg <= ch_next;
      cmd_reg <= cmd_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      st_reg <= st_next;
      bc_reg <= bc_next;
      ph_reg <= ph_next;
      tx_s_reg <= {tx_s_reg[0], tx_active_pin};
      rx_s_reg <= {rx_s_reg[0], rx_active_pin};
      lamp_reg <= lamp;
    end
  end

  // Assertions
  property p_upload_blue;
    @(posedge aclk) disable iff (!aresetn)
      (st_reg == OSI_S_RUN && ctrl_reg[OSI_CTRL_UPLD]) |=> (lamp_reg[2].blue == $past(ph_reg) && !lamp_reg[2].red);
  endproperty
  a_upload_blue: assert property (p_upload_blue) else $error("upload lamp wrong");
  property p_boot_third_off;
    @(posedge aclk) disable iff (!aresetn)
      (st_reg == OSI_S_RUN && ctrl_reg[OSI_CTRL_BOOT] && !ctrl_reg[OSI_CTRL_UPLD]) |=> (lamp_reg[2] == '0);
  endproperty
  a_boot_third_off: assert property (p_boot_third_off) else $error("boot third lamp lit");
  property p_fault_red;
    @(posedge aclk) disable iff (!aresetn)
      (st_reg == OSI_S_RUN && ctrl_reg == 4'h1 && ev_act == 4'h0) |=> (lamp_reg[1].red && !lamp_reg[1].green);
  endproperty
  a_fault_red: assert property (p_fault_red) else $error("fault not red");
  property p_ch_flag;
    @(posedge aclk) disable iff (!aresetn) ch_wr[0] |=> stat_reg[OSI_ST_CH0] && ch_act[0];
  endproperty
  a_ch_flag: assert property (p_ch_flag) else $error("channel write not flagged");
  property p_term;
    @(posedge aclk) disable iff (!aresetn)
      (wr_fire && awaddr_next == OSI_OFF_TERM && wstrb_next[0]) |=> bus_terminator == $past(wdata_next[0]);
  endproperty
  a_term: assert property (p_term) else $error("terminator not applied");
  property p_freq_range;
    @(posedge aclk) disable iff (!aresetn) pwm_freq_khz >= OSI_FREQ_MIN && pwm_freq_khz <= OSI_FREQ_MAX;
  endproperty
  a_freq_range: assert property (p_freq_range) else $error("pwm frequency out of range");
  property p_rx_follow;
    @(posedge aclk) disable iff (!aresetn) rx_s_reg[1] |=> rx_act;
  endproperty
  a_rx_follow: assert property (p_rx_follow) else $error("rx activity not seen");
  property p_seq_green_first;
    @(posedge aclk) disable iff (!aresetn) (st_reg == OSI_S_GREEN) |=> !lamp_reg[0].red && !lamp_reg[0].blue;
  endproperty
  a_seq_green_first: assert property (p_seq_green_first) else $error("startup colour wrong");
endmodule : osi_top

// file: bench/osi_link_partner.sv
// Link partner model driving transmit and receive activity levels
module osi_link_partner (
  input wire logic aclk,
  input wire logic tx_go,
  input wire logic rx_go,
  input wire logic [7:0] len,
  output logic tx_active_pin,
  output logic rx_active_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int tx_cnt = 0;
  int rx_cnt = 0;
  // Each start pulse holds one activity level for len cycles
  always @(posedge aclk) begin
    if (tx_go) tx_cnt <= len;
    else if (tx_cnt > 0) tx_cnt <= tx_cnt - 1;
    if (rx_go) rx_cnt <= len;
    else if (rx_cnt > 0) rx_cnt <= rx_cnt - 1;
  end
  // Levels fall back to idle when a burst ends
  assign tx_active_pin = (tx_cnt > 0);
  assign rx_active_pin = (rx_cnt > 0);
endmodule : osi_link_partner

// file: bench/tb.sv
// Self-checking bench for the status lamp block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import osi_pkg::*;
  localparam int BC = 4;
  localparam int CC = 40;
  localparam int AC = 8;
  logic aclk = 0, aresetn = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic tx_active_pin, rx_active_pin, tx_lamp, rx_lamp, bus_terminator, irq;
  logic [3:0] pwm_freq_khz;
  osi_rgb_t first_channel_lamp, second_channel_lamp, third_channel_lamp;
  logic tx_go = 0, rx_go = 0;
  logic [7:0] len = 8'h10;
  int n_fail = 0, samples_checked = 0;
  integer seed = 32'h0e22;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  // Indication table: address, value, whole-lamp compare, expected
  logic [7:0] t_a [9] = '{8'h18, 8'h18, 8'h18, 8'h18, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [31:0] t_v [9] = '{32'h1, 32'h2, 32'h4, 32'h8, 32'h4, 32'h8, 32'hc, 32'h2, 32'h1};
  logic t_f [9] = '{0, 0, 0, 0, 0, 0, 0, 1, 1};
  logic [8:0] t_e [9] = '{9'h4, 9'h2, 9'h1, 9'h3, 9'h6, 9'h7, 9'h7, 9'h1b6, 9'h124};
  logic [3:0] fv [4] = '{4'h8, 4'h9, 4'h0, 4'h3};
  logic [3:0] fe [4] = '{4'h8, 4'h8, 4'h8, 4'h3};

  osi_top #(.BLINK_CYC(BC), .CHG_CYC(CC), .ACT_CYC(AC)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .tx_active_pin, .rx_active_pin, .first_channel_lamp, .second_channel_lamp,
    .third_channel_lamp, .tx_lamp, .rx_lamp, .bus_terminator, .pwm_freq_khz, .irq);
  osi_link_partner link (.aclk, .tx_go, .rx_go, .len, .tx_active_pin, .rx_active_pin);

  // Clock at 100 MHz
  always #5 aclk = ~aclk;

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic end_sim;
    if (n_fail == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  // Bounded wait for a handshake signal, sampled mid-cycle
  task automatic wait_hi(ref logic s);
    int i;
    i = 0;
    do begin
      @(negedge aclk);
      i++;
    end while (s !== 1'b1 && i < 64);
    if (s !== 1'b1) n_fail++;
  endtask : wait_hi

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw;
    bit w;
    int i;
    aw = 0;
    w = 0;
    bq.push_back(er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Address and data may be taken in either order
    for (i = 0; i < 64 && !(aw && w); i++) begin
      @(negedge aclk);
      aw |= s_axi_awvalid & s_axi_awready;
      w |= s_axi_wvalid & s_axi_wready;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    wait_hi(s_axi_bvalid);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    wait_hi(s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    wait_hi(s_axi_rvalid);
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  // Collect colours and dark moments of all three channel lamps over two blink periods
  task automatic watch(output logic [8:0] orv, output logic [2:0] offs);
    orv = '0;
    offs = '0;
    repeat (4 * BC) begin
      @(negedge aclk);
      orv |= {first_channel_lamp, second_channel_lamp, third_channel_lamp};
      offs |= {first_channel_lamp == 3'b000, second_channel_lamp == 3'b000, third_channel_lamp == 3'b000};
    end
  endtask : watch

  // Response monitor takes the oldest note for each answer
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0) check(s_axi_bresp, bq.pop_front());
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0) check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
  end

  // Watchdog against a hung run
  initial begin
    #100000;
    n_fail++;
    end_sim;
  end

  // Main sequence
  initial begin
    int k, n;
    logic [2:0] v;
    logic [2:0] seq [4];
    logic [8:0] orv;
    logic [2:0] offs;
    logic [31:0] cv;
    logic tl, rh;
    n = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (k = 0; k < 200 && n < 4; k++) begin
      @(negedge aclk);
      v = first_channel_lamp;
      if (v !== 3'b000 && (n == 0 || v !== seq[n-1])) begin
        seq[n] = v;
        n++;
      end
    end
    check({seq[0], seq[1], seq[2]}, 9'b010_100_001);
    check(seq[3], 3'b110);
    @(negedge aclk);
    check({second_channel_lamp, third_channel_lamp}, 6'b110_110);
    check({tx_lamp, rx_lamp}, 2'b10);
    axi_rd(OSI_OFF_EVENT, 34'h40);
    // Channel write without both low byte lanes is ignored
    @(posedge aclk);
    s_axi_wstrb <= 4'h1;
    axi_wr(OSI_OFF_CH2, 32'h5, 2'b00);
    s_axi_wstrb <= 4'hf;
    axi_rd(OSI_OFF_CH2, 34'h0);
    axi_rd(OSI_OFF_FREQ, 34'h1);
    check(pwm_freq_khz, 4'h1);
    for (k = 0; k < 4; k++) begin
      axi_wr(OSI_OFF_FREQ, {28'h0, fv[k]}, 2'b00);
      @(negedge aclk);
      check(pwm_freq_khz, fe[k]);
    end
    axi_wr(OSI_OFF_TERM, 32'h1, 2'b00);
    @(negedge aclk);
    check(bus_terminator, 1'b1);
    axi_rd(OSI_OFF_TERM, 34'h1);
    axi_rd(8'h40, {2'b10, 32'h0});
    axi_wr(8'h40, 32'h5, 2'b10);
    // channel write while above zero, with interrupt
    axi_wr(OSI_OFF_MASK, 32'h1, 2'b00);
    cv = ($random(seed) & 32'hffff) | 32'h1;
    axi_wr(OSI_OFF_CH0, cv, 2'b00);
    repeat (2) @(negedge aclk);
    check(irq, 1'b1);
    watch(orv, offs);
    check({orv[8:6], offs[2]}, 4'b0101);
    axi_rd(OSI_OFF_STAT, 34'h1);
    axi_rd(OSI_OFF_CH0, {2'b00, cv});
    axi_wr(OSI_OFF_STAT, 32'h1, 2'b00);
    repeat (2) @(negedge aclk);
    check(irq, 1'b0);
    repeat (CC) @(negedge aclk);
    watch(orv, offs);
    check({orv[8:6], offs[2]}, 4'b0100);
    axi_wr(OSI_OFF_CH1, 32'h0, 2'b00);
    watch(orv, offs);
    check({orv[5:3], offs[1]}, 4'b1101);
    repeat (CC) @(negedge aclk);
    watch(orv, offs);
    check({orv[5:3], offs[1]}, 4'b1100);
    for (k = 0; k < 9; k++) begin
      axi_wr(t_a[k], t_v[k], 2'b00);
      watch(orv, offs);
      if (t_f[k]) check(orv, t_e[k]);
      else check({orv[6], orv[3], orv[0]}, t_e[k]);
      axi_wr(OSI_OFF_CTRL, 32'h0, 2'b00);
      repeat (CC + 8) @(negedge aclk);
    end
    tl = 1'b1;
    rh = 1'b0;
    @(posedge aclk);
    len <= 8'h10 + ($random(seed) & 8'h0f);
    tx_go <= 1'b1;
    rx_go <= 1'b1;
    @(posedge aclk);
    tx_go <= 1'b0;
    rx_go <= 1'b0;
    for (k = 0; k < 24; k++) begin
      @(negedge aclk);
      tl &= tx_lamp;
      rh |= rx_lamp;
    end
    check(tl, 1'b0);
    check(rh, 1'b1);
    repeat (64) @(negedge aclk);
    check({tx_lamp, rx_lamp}, 2'b10);
    end_sim;
  end
endmodule : tb
